// ===== adc_i2c_pkg.sv
// Constants, enumerations and carrier structs for the converter serial port
package adc_i2c_pkg;
   // Bus addressing
   localparam logic [2:0] DEV_ADDR_HI = 3'h2;
   localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
   localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Address select pin states
   localparam logic [1:0] SEL_GND = 2'h0;
   localparam logic [1:0] SEL_VDD = 2'h1;
   // Pointer codes, low nibble of the pointer byte
   localparam logic [3:0] PTR_RESULT = 4'h0;
   localparam logic [3:0] PTR_ALERT = 4'h1;
   localparam logic [3:0] PTR_CFG = 4'h2;
   localparam logic [3:0] PTR_CYCLE = 4'h3;
   localparam logic [3:0] PTR_UPPER = 4'h4;
   localparam logic [3:0] PTR_LOWER = 4'h5;
   localparam logic [3:0] PTR_HYST = 4'h6;
   // Configuration and alert flag bit positions
   localparam int CFG_POL = 0;
   localparam int CFG_CLR = 1;
   localparam int CFG_DIS = 2;
   localparam int CFG_BUSY = 3;
   localparam int FLAG_LO = 0;
   localparam int FLAG_HI = 1;
   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CYCLE_RESET = 8'h00;
   localparam logic [11:0] UPPER_RESET = 12'hfff;
   localparam logic [11:0] LOWER_RESET = 12'h000;
   localparam logic [11:0] HYST_RESET = 12'h000;
   // APB map
   localparam logic [11:0] APB_RESULT = 12'h000;
   localparam logic [11:0] APB_STATUS = 12'h004;
   localparam logic [11:0] APB_PTR = 12'h008;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_IGNORE} bus_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      bus_state_e st;
      logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
      logic [1:0] sel_s1, sel_s2;
      logic [3:0] bit_cnt;
      logic [7:0] shreg, hold, ptr, cfg, alert_st, cyc;
      logic [1:0] byte_idx;
      logic rw, ara, rd_idx, hs_mode, pending;
      logic sda_oe, scl_oe, alert_oe;
      logic [11:0] upper, lower, hyst, result;
      logic pready, pslverr;
      logic [31:0] prdata;
   } port_state_s;

   localparam port_state_s STATE_RESET = '{st: ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
      scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, cfg: CFG_RESET, cyc: CYCLE_RESET,
      upper: UPPER_RESET, lower: LOWER_RESET, hyst: HYST_RESET, default: '0};
endpackage

// ===== adc_i2c_slave_alert_port.sv
// Two-wire slave port with limit alert output and APB side port
//
// Functional notes
// - Own address top three bits are 010
// - Low address bits follow address-select pin state
// - START begins; eight bits shifted MSB first
// - Acknowledge own address, otherwise stay idle
// - Direction bit zero writes, one reads
// - Nine clocks per byte, data changes low
// - Direction fixed by first address byte
// - Lone byte after address loads pointer
// - One byte completes an 8-bit register
// - Two bytes complete a 12-bit register
// - Next byte after register is new pointer
// - Pointer kept across read transfers
// - Byte count of reads depends on register
// - Alert pin shows alert or busy
// - Open-drain alert, polarity from D0, low
// - D2 set disables the alert
// - Answer alert response address only when alerting
// - Alert on result above upper, below lower
// - Clear by D1 write or hysteresis return
// - Slave only, never starts a transfer
// - Ignore high-speed code, note until STOP
// - Stretch SCL on read while converting
`timescale 1ns/1ps
module adc_i2c_slave_alert_port #(
   parameter logic [3:0] ADDR_LOW_GND = 4'h1,
   parameter logic [3:0] ADDR_LOW_VDD = 4'h2,
   parameter logic [3:0] ADDR_LOW_FLOAT = 4'h4
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Two-wire bus, open drain
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_oe,
   output logic o_sda_oe,
   // Address select strap: 0 ground, 1 supply, 2 floating
   input wire logic [1:0] i_addr_select_pin,
   // Alert/busy pin, open drain
   output logic o_alert_oe,
   // APB slave
   input wire adc_i2c_pkg::apb_req_s i_apb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   import adc_i2c_pkg::*;

   port_state_s s;
   port_state_s next_s;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [6:0] own_addr;
   logic addr_match, ara_hit, hs_code, alert_asserted, pin_asserted;
   logic rx_done, res_wr, two_byte;
   logic [7:0] rd_byte;
   logic [11:0] res_val;

   ////////////////////////////////////////////////////////////////////////////
   // Line events, seen only through the second synchroniser stage
   assign scl_rise = s.scl_s2 && !s.scl_d;
   assign scl_fall = !s.scl_s2 && s.scl_d;
   assign start_det = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
   assign stop_det = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;

   always_comb begin
      if (s.sel_s2 == SEL_GND) begin
         own_addr = {DEV_ADDR_HI, ADDR_LOW_GND};
      end else if (s.sel_s2 == SEL_VDD) begin
         own_addr = {DEV_ADDR_HI, ADDR_LOW_VDD};
      end else begin
         own_addr = {DEV_ADDR_HI, ADDR_LOW_FLOAT};
      end
   end

   assign alert_asserted = !s.cfg[CFG_DIS] && (|s.alert_st[FLAG_HI:FLAG_LO]);
   // Busy mode follows an outstanding conversion instead of the limit flags
   assign pin_asserted = s.cfg[CFG_BUSY] ? s.pending : alert_asserted;
   assign addr_match = (s.shreg[7:1] == own_addr);
   assign ara_hit = (s.shreg[7:1] == ALERT_RESP_ADDR) && s.shreg[0] && alert_asserted;
   assign hs_code = (s.shreg[7:3] == HS_CODE_PREFIX);
   assign rx_done = (s.st == ST_RX) && scl_fall && (s.bit_cnt == BITS_PER_BYTE);
   assign res_wr = i_apb.psel && i_apb.penable && s.pready && i_apb.pwrite
      && (i_apb.paddr == APB_RESULT);
   assign res_val = i_apb.pwdata[11:0];
   assign two_byte = (s.ptr[3:0] == PTR_RESULT) || (s.ptr[3:0] == PTR_UPPER)
      || (s.ptr[3:0] == PTR_LOWER) || (s.ptr[3:0] == PTR_HYST);

   ////////////////////////////////////////////////////////////////////////////
   // Read byte selection
   always_comb begin
      rd_byte = 8'h00;
      if (s.ara) begin
         rd_byte = {own_addr, 1'b0};
      end else begin
         case (s.ptr[3:0])
            PTR_RESULT: rd_byte = s.rd_idx ? s.result[7:0] :
               {alert_asserted, 3'h0, s.result[11:8]};
            PTR_ALERT: rd_byte = s.alert_st;
            PTR_CFG: rd_byte = s.cfg;
            PTR_CYCLE: rd_byte = s.cyc;
            PTR_UPPER: rd_byte = s.rd_idx ? s.upper[7:0] : {4'h0, s.upper[11:8]};
            PTR_LOWER: rd_byte = s.rd_idx ? s.lower[7:0] : {4'h0, s.lower[11:8]};
            PTR_HYST: rd_byte = s.rd_idx ? s.hyst[7:0] : {4'h0, s.hyst[11:8]};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_s = s;
      next_s.scl_s1 = i_scl;
      next_s.scl_s2 = s.scl_s1;
      next_s.scl_d = s.scl_s2;
      next_s.sda_s1 = i_sda;
      next_s.sda_s2 = s.sda_s1;
      next_s.sda_d = s.sda_s2;
      next_s.sel_s1 = i_addr_select_pin;
      next_s.sel_s2 = s.sel_s1;

      // Bus engine; it only ever answers, it never drives a START
      case (s.st)
         ST_ADDR: begin
            if (scl_rise) begin
               next_s.shreg = {s.shreg[6:0], s.sda_s2};
               next_s.bit_cnt = s.bit_cnt + 4'h1;
            end else if (scl_fall && (s.bit_cnt == BITS_PER_BYTE)) begin
               next_s.rw = s.shreg[0];
               next_s.rd_idx = 1'b0;
               next_s.byte_idx = 2'h0;
               if (addr_match || ara_hit) begin
                  next_s.ara = ara_hit && !addr_match;
                  next_s.sda_oe = 1'b1;
                  // A read while converting holds SCL through the ack clock
                  next_s.scl_oe = s.shreg[0] && s.pending;
                  next_s.st = ST_ACK;
               end else begin
                  // Master code is left unanswered; the bus is then high speed
                  next_s.hs_mode = s.hs_mode || hs_code;
                  next_s.st = ST_IGNORE;
               end
            end
         end
         ST_ACK: begin
            if (s.scl_oe && !s.pending) begin
               next_s.scl_oe = 1'b0;
            end
            if (scl_fall && !s.scl_oe) begin
               next_s.bit_cnt = 4'h0;
               if (s.rw) begin
                  next_s.shreg = rd_byte;
                  next_s.sda_oe = !rd_byte[7];
                  next_s.st = ST_TX;
               end else begin
                  next_s.sda_oe = 1'b0;
                  next_s.st = ST_RX;
               end
            end
         end
         ST_RX: begin
            if (scl_rise) begin
               next_s.shreg = {s.shreg[6:0], s.sda_s2};
               next_s.bit_cnt = s.bit_cnt + 4'h1;
            end else if (rx_done) begin
               next_s.sda_oe = 1'b1;
               next_s.st = ST_ACK;
            end
         end
         ST_TX: begin
            if (scl_rise) begin
               next_s.bit_cnt = s.bit_cnt + 4'h1;
               // Released a one but the line is low: lost arbitration
               if (!s.sda_oe && !s.sda_s2) begin
                  next_s.st = ST_IGNORE;
               end
            end else if (scl_fall) begin
               if (s.bit_cnt == BITS_PER_BYTE) begin
                  next_s.sda_oe = 1'b0;
                  next_s.st = ST_MACK;
               end else begin
                  next_s.shreg = {s.shreg[6:0], 1'b0};
                  next_s.sda_oe = !s.shreg[6];
               end
            end
         end
         ST_MACK: begin
            if (scl_rise) begin
               if (s.sda_s2) begin
                  next_s.st = ST_IGNORE;
               end else begin
                  next_s.rd_idx = two_byte && !s.ara && !s.rd_idx;
                  next_s.st = ST_ACK;
               end
            end
         end
         default: begin
         end
      endcase

      // Write bytes: pointer first, then one or two data bytes
      if (rx_done) begin
         if (s.byte_idx == 2'h0) begin
            next_s.ptr = s.shreg;
            next_s.byte_idx = 2'h1;
            if (|s.shreg[7:4]) begin
               next_s.pending = 1'b1;
            end
         end else begin
            next_s.byte_idx = 2'h0;
            case (s.ptr[3:0])
               PTR_ALERT: next_s.alert_st = s.alert_st & ~s.shreg;
               PTR_CFG: begin
                  next_s.cfg = s.shreg & ~(8'h01 << CFG_CLR);
                  if (s.shreg[CFG_CLR]) begin
                     next_s.alert_st = 8'h00;
                  end
               end
               PTR_CYCLE: next_s.cyc = s.shreg;
               default: begin
                  if (s.byte_idx == 2'h1) begin
                     next_s.hold = s.shreg;
                     next_s.byte_idx = 2'h2;
                  end else if (s.ptr[3:0] == PTR_UPPER) begin
                     next_s.upper = {s.hold[3:0], s.shreg};
                  end else if (s.ptr[3:0] == PTR_LOWER) begin
                     next_s.lower = {s.hold[3:0], s.shreg};
                  end else if (s.ptr[3:0] == PTR_HYST) begin
                     next_s.hyst = {s.hold[3:0], s.shreg};
                  end
               end
            endcase
         end
      end

      if (start_det) begin
         next_s.st = ST_ADDR;
         next_s.bit_cnt = 4'h0;
         next_s.sda_oe = 1'b0;
         next_s.scl_oe = 1'b0;
      end else if (stop_det) begin
         next_s.st = ST_IDLE;
         next_s.sda_oe = 1'b0;
         next_s.scl_oe = 1'b0;
         next_s.hs_mode = 1'b0;
      end

      // APB: one wait state, write lands at the edge pready is sampled high
      next_s.pready = 1'b0;
      if (i_apb.psel && i_apb.penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.pslverr = 1'b0;
         if (i_apb.paddr == APB_RESULT) begin
            next_s.prdata = {20'h0, s.result};
         end else if (i_apb.paddr == APB_STATUS) begin
            next_s.prdata = {24'h0, s.hs_mode, s.pending, pin_asserted,
               s.cfg[CFG_DIS], 2'h0, s.alert_st[FLAG_HI:FLAG_LO]};
         end else if (i_apb.paddr == APB_PTR) begin
            next_s.prdata = {24'h0, s.ptr};
         end else begin
            next_s.prdata = 32'h0;
            next_s.pslverr = 1'b1;
         end
      end
      // A fresh result ends the conversion; a new request in the same cycle wins
      if (res_wr) begin
         next_s.result = res_val;
         next_s.pending = rx_done && (s.byte_idx == 2'h0) && (|s.shreg[7:4]);
         if (({1'b0, res_val} + {1'b0, s.hyst}) <= {1'b0, s.upper}) begin
            next_s.alert_st[FLAG_HI] = 1'b0;
         end
         if ({1'b0, res_val} >= ({1'b0, s.lower} + {1'b0, s.hyst})) begin
            next_s.alert_st[FLAG_LO] = 1'b0;
         end
         // Set after the clears so an event never gets lost
         if (!s.cfg[CFG_DIS] && (res_val > s.upper)) begin
            next_s.alert_st[FLAG_HI] = 1'b1;
         end
         if (!s.cfg[CFG_DIS] && (res_val < s.lower)) begin
            next_s.alert_st[FLAG_LO] = 1'b1;
         end
      end

      // Active high drives low while idle; released line reads high
      next_s.alert_oe = s.cfg[CFG_POL] ? !pin_asserted : pin_asserted;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign o_scl_oe = s.scl_oe;
   assign o_sda_oe = s.sda_oe;
   assign o_alert_oe = s.alert_oe;
   assign o_prdata = s.prdata;
   assign o_pready = s.pready;
   assign o_pslverr = s.pslverr;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   a_ack_own_addr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.st == ST_ADDR && scl_fall && s.bit_cnt == BITS_PER_BYTE && addr_match
         && !start_det && !stop_det) |=> s.sda_oe && s.st == ST_ACK)
      else $error("own address not acknowledged");
   a_no_ack_foreign: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.st == ST_ADDR && scl_fall && s.bit_cnt == BITS_PER_BYTE && !addr_match
         && !ara_hit) |=> !s.sda_oe)
      else $error("foreign address acknowledged");
   a_hs_code_nack: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.st == ST_ADDR && scl_fall && s.bit_cnt == BITS_PER_BYTE && hs_code
         && !stop_det) |=> s.hs_mode && !s.sda_oe)
      else $error("high speed code mishandled");
   a_ptr_load: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (rx_done && s.byte_idx == 2'h0) |=> s.ptr == $past(s.shreg) && s.byte_idx == 2'h1)
      else $error("pointer byte not loaded");
   a_ptr_kept_read: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.st == ST_TX || s.st == ST_MACK) |=> $stable(s.ptr))
      else $error("pointer changed during read");
   a_stretch_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.scl_oe && s.pending && !start_det && !stop_det) |=> s.scl_oe)
      else $error("clock released while converting");
   a_alert_set: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (res_wr && !s.cfg[CFG_DIS] && !s.cfg[CFG_BUSY] && res_val > s.upper)
         |=> s.alert_st[FLAG_HI]
         ##1 (s.alert_oe == !s.cfg[CFG_POL]))
      else $error("upper violation not flagged");
   a_disabled_quiet: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.cfg[CFG_DIS] && !s.cfg[CFG_BUSY] && !s.cfg[CFG_POL]) [*2] |-> !s.alert_oe)
      else $error("disabled alert still driven");
   a_cfg_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (rx_done && s.byte_idx == 2'h1 && s.ptr[3:0] == PTR_CFG && s.shreg[CFG_CLR]
         && !res_wr) |=> s.alert_st == 8'h00)
      else $error("clear bit did not clear alert");
   a_slave_only: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s.sda_oe |-> (s.st == ST_ACK || s.st == ST_TX))
      else $error("data driven outside a slave slot");
   a_busy_output: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.cfg[CFG_BUSY] && !s.cfg[CFG_POL] && s.pending) |=> s.alert_oe)
      else $error("busy output not driven");
   a_limit_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (rx_done && s.byte_idx == 2'h1 && s.ptr[3:0] == PTR_UPPER)
         |=> s.byte_idx == 2'h2 && $stable(s.upper))
      else $error("limit written from one byte");
   a_next_pointer: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (rx_done && (s.byte_idx == 2'h2 || (s.byte_idx == 2'h1 && (s.ptr[3:0] == PTR_ALERT
         || s.ptr[3:0] == PTR_CFG || s.ptr[3:0] == PTR_CYCLE)))) |=> s.byte_idx == 2'h0)
      else $error("next byte not taken as pointer");
   a_read_pairing: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (s.st == ST_MACK && scl_rise && !s.sda_s2 && two_byte && !s.ara && !s.rd_idx)
         |=> s.rd_idx && s.st == ST_ACK)
      else $error("low byte not selected after high byte");

   c_write_reg: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      rx_done && s.byte_idx == 2'h2);
   c_read_ack: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s.st == ST_MACK && scl_rise && !s.sda_s2);
   c_stretch: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $fell(s.scl_oe));
   c_ara: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(s.ara));
   c_hs_code: cover property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(s.hs_mode));
endmodule

// ===== i2c_master_model.sv
// Behavioural two-wire bus master that drives the port's far side
`timescale 1ns/1ps
module i2c_master_model (
   // Clock
   input wire logic i_clk,
   // Wired bus levels
   input wire logic i_scl,
   input wire logic i_sda,
   // Master drive, 1 releases the line to the pull-up
   output logic o_scl,
   output logic o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic q(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Raise SCL and honour clock stretching, bounded so a stuck slave cannot hang us
   task automatic hi();
      int k;
      o_scl <= 1'b1;
      q(1);
      k = 0;
      while (i_scl !== 1'b1 && k < 4000) begin
         q(1);
         k++;
      end
      q(3);
   endtask
   // One clock: data set mid-low, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      o_sda <= b;
      q(4);
      hi();
      r = i_sda;
      q(4);
      o_scl <= 1'b0;
      q(4);
   endtask
   task automatic start();
      q(1);
      o_sda <= 1'b1;
      q(4);
      hi();
      q(4);
      o_sda <= 1'b0;
      q(8);
      o_scl <= 1'b0;
      q(4);
   endtask
   task automatic stop();
      o_sda <= 1'b0;
      q(4);
      hi();
      o_sda <= 1'b1;
      q(8);
   endtask
   // Eight bits MSB first, then the slave's acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, r);
      ak = ~r;
   endtask
   // Last byte of a read gets a not-acknowledge
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(last, r);
   endtask
endmodule

// ===== tb.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
module tb;
   import adc_i2c_pkg::*;
   localparam logic [3:0] LOW_G = 4'h1;
   localparam logic [3:0] LOW_V = 4'h2;
   localparam logic [3:0] LOW_F = 4'h4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] pin = 2'h0;
   apb_req_s apb_r = '0;
   logic m_scl, m_sda, scl_oe, sda_oe, alert_oe, pready, pslverr;
   logic [31:0] prdata;
   wire logic scl = m_scl & ~scl_oe;
   wire logic sda = m_sda & ~sda_oe;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   logic [6:0] me;
   always #2.5 clk = ~clk;
   adc_i2c_slave_alert_port #(.ADDR_LOW_GND(LOW_G), .ADDR_LOW_VDD(LOW_V),
      .ADDR_LOW_FLOAT(LOW_F)) u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_scl(scl),
      .i_sda(sda), .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .i_addr_select_pin(pin),
      .o_alert_oe(alert_oe), .i_apb(apb_r), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr));
   i2c_master_model u_master (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl(m_scl),
      .o_sda(m_sda));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Whole run needs roughly 13k cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         failures++;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
      int k;
      apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      apb_r.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      r = prdata;
      er = pslverr;
      apb_r <= '0;
      @(posedge clk);
   endtask
   task automatic setres(input logic [11:0] v);
      logic [31:0] r;
      logic e;
      apb(1'b1, APB_RESULT, {20'h0, v}, r, e);
      repeat (4) @(posedge clk);
   endtask
   task automatic stat(output logic [31:0] r);
      logic e;
      apb(1'b0, APB_STATUS, 32'h0, r, e);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] b[$], output logic ak);
      logic k;
      u_master.start();
      u_master.wbyte({a, 1'b0}, ak);
      foreach (b[i]) begin
         u_master.wbyte(b[i], k);
         ak &= k;
      end
      u_master.stop();
   endtask
   task automatic rd(input logic [6:0] a, input int n, output logic [15:0] d,
      output logic ak);
      logic [7:0] x;
      u_master.start();
      u_master.wbyte({a, 1'b1}, ak);
      d = '0;
      for (int i = 0; i < n; i++) begin
         u_master.rbyte(i == n - 1, x);
         d = {d[7:0], x};
      end
      u_master.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_addr();
      logic [3:0] lows [3];
      logic ak;
      logic [31:0] r;
      lows = '{LOW_G, LOW_V, LOW_F};
      for (int p = 0; p < 3; p++) begin
         pin <= 2'(p);
         repeat (6) @(posedge clk);
         wr({DEV_ADDR_HI, lows[p]}, '{8'h00}, ak);
         chk("own addr ack", 32'(ak), 32'h1);
         wr({DEV_ADDR_HI, lows[(p + 1) % 3]}, '{8'h00}, ak);
         chk("other addr ack", 32'(ak), 32'h0);
      end
      pin <= 2'h0;
      repeat (6) @(posedge clk);
      wr({3'h6, LOW_G}, '{8'h00}, ak);
      chk("high bits ack", 32'(ak), 32'h0);
      u_master.start();
      u_master.wbyte(8'h08, ak);
      chk("hs code ack", 32'(ak), 32'h0);
      stat(r);
      chk("hs mode", 32'(r[7]), 32'h1);
      u_master.stop();
      stat(r);
      chk("hs mode after stop", 32'(r[7]), 32'h0);
      $display("test addr done");
   endtask
   task automatic t_stretch();
      logic ak;
      logic [15:0] d;
      int k;
      wr(me, '{PTR_CFG, 8'h08, 8'h10}, ak);
      chk("busy mode writes", 32'(ak), 32'h1);
      fork
         rd(me, 2, d, ak);
         begin
            k = 0;
            while (scl_oe !== 1'b1 && k < 2000) begin
               @(posedge clk);
               k++;
            end
            repeat (40) @(posedge clk);
            chk("scl held", 32'(scl_oe), 32'h1);
            chk("busy pin", 32'(alert_oe), 32'h1);
            setres(12'h3ab);
            chk("busy released", 32'(alert_oe), 32'h0);
         end
      join
      chk("result read", 32'(d), 32'h03ab);
      wr(me, '{PTR_CFG, 8'h00}, ak);
      $display("test stretch done");
   endtask
   task automatic t_ptr();
      logic ak, e;
      logic [15:0] d;
      logic [31:0] r;
      wr(me, '{PTR_UPPER, 8'h01, 8'h23, PTR_LOWER, 8'h00, 8'h10, PTR_HYST, 8'h00,
         8'h05}, ak);
      chk("multi write ack", 32'(ak), 32'h1);
      wr(me, '{PTR_UPPER}, ak);
      apb(1'b0, APB_PTR, 32'h0, r, e);
      chk("pointer", r, 32'h4);
      for (int i = 0; i < 2; i++) begin
         rd(me, 2, d, ak);
         chk("upper read", 32'(d), 32'h0123);
      end
      wr(me, '{PTR_LOWER}, ak);
      rd(me, 2, d, ak);
      chk("lower read", 32'(d), 32'h0010);
      wr(me, '{PTR_CFG}, ak);
      rd(me, 1, d, ak);
      chk("cfg read", 32'(d), 32'h0000);
      apb(1'b0, 12'h00c, 32'h0, r, e);
      chk("unmapped err", 32'(e), 32'h1);
      $display("test pointer done");
   endtask
   task automatic t_alert();
      logic ak;
      logic [15:0] d;
      logic [31:0] r;
      setres(12'h200);
      chk("alert low drive", 32'(alert_oe), 32'h1);
      rd(ALERT_RESP_ADDR, 1, d, ak);
      chk("ara ack", 32'(ak), 32'h1);
      chk("ara data", 32'(d), 32'({me, 1'b0}));
      wr(me, '{PTR_CFG, 8'h03}, ak);
      chk("cleared active high", 32'(alert_oe), 32'h1);
      rd(ALERT_RESP_ADDR, 1, d, ak);
      chk("ara nack", 32'(ak), 32'h0);
      setres(12'h005);
      chk("low alert", 32'(alert_oe), 32'h0);
      setres(12'h012);
      chk("within hyst", 32'(alert_oe), 32'h0);
      setres(12'h015);
      chk("hyst clear", 32'(alert_oe), 32'h1);
      setres(12'h200);
      chk("active high alert", 32'(alert_oe), 32'h0);
      wr(me, '{PTR_CFG, 8'h04}, ak);
      setres(12'h200);
      stat(r);
      chk("disabled flag", r & 32'h23, 32'h02);
      chk("disabled pin", 32'(alert_oe), 32'h0);
      wr(me, '{PTR_ALERT}, ak);
      rd(me, 1, d, ak);
      chk("status read", 32'(d), 32'h0002);
      wr(me, '{PTR_ALERT, 8'h02, PTR_CYCLE, 8'h05}, ak);
      stat(r);
      chk("status cleared", r & 32'h23, 32'h00);
      wr(me, '{PTR_CYCLE}, ak);
      rd(me, 1, d, ak);
      chk("cycle read", 32'(d), 32'h0005);
      wr(me, '{PTR_CFG, 8'h00}, ak);
      setres(12'h200);
      wr(me, '{PTR_CFG, 8'h02}, ak);
      stat(r);
      chk("d1 clears", r & 32'h23, 32'h00);
      $display("test alert done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      me = {DEV_ADDR_HI, LOW_G};
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_addr();
      t_stretch();
      t_ptr();
      t_alert();
      conclude();
   end
endmodule
